/* File: testbench/bchi_mem_model.sv */
// memory array stand-in that acknowledges each word after a delay
`default_nettype none

module bchi_mem_model
(
   input  wire logic       ref_clk_in,   // system clock
   input  wire logic       sys_rst_in,   // sync reset, high
   input  wire logic       mem_req_in,   // access in service
   input  wire logic [3:0] delay_in,     // wait cycles, at least one
   output var  logic       mem_ack_out   // one-cycle word ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;                 // cycles spent on this word

   ////////////////////////////////////////////////////////////////////
   // the ack clears the count, so even a zero delay would not ack the stale
   // request in the cycle after the last ack; the bench never hands in zero
   always @(posedge ref_clk_in)
   begin
      if (sys_rst_in || !mem_req_in || mem_ack_out)
      begin
         wait_reg    <= #1 4'h0;
         mem_ack_out <= #1 1'b0;
      end
      else if (wait_reg == delay_in)
         mem_ack_out <= #1 1'b1;
      else
         wait_reg <= #1 wait_reg + 4'h1;
   end
endmodule // bchi_mem_model
`default_nettype wire

/* File: testbench/bchi_top_asserts.sv */
// concurrent checks on the channel interface ports
`default_nettype none

module bchi_top_asserts
(
   input wire logic        ref_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        bus_invalid_n_in,
   input wire logic        data_access_start_n_in,
   input wire logic        instr_access_start_n_in,
   input wire logic [1:0]  data_space_code_in,
   input wire logic [2:0]  transfer_option_code_in,
   input wire logic        data_burst_want_n_in,
   input wire logic        mem_ack_in,
   input wire logic        data_done_n_out,
   input wire logic        data_done_oe_out,
   input wire logic        data_burst_grant_n_out,
   input wire logic        data_burst_grant_oe_out,
   input wire logic        instr_done_oe_out,
   input wire logic        instr_burst_grant_oe_out,
   input wire logic        chained_reset_out_n_out,
   input wire logic        mem_req_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic        configured_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   ////////////////////////////////////////////////////////////////////
   // a refused request on an idle block leaves array and ready quiet
   property p_quiet(bad);
      data_access_start_n_in && instr_access_start_n_in ##1
      (!data_access_start_n_in && instr_access_start_n_in && bad &&
       !mem_req_out && !data_done_oe_out)
      |=> !mem_req_out ##1 !mem_req_out ##1 data_done_n_out;
   endproperty

   chk_invalid_ignored: assert property (p_quiet(!bus_invalid_n_in))
      else $error("request taken while bus invalid");
   chk_space_ignored: assert property (p_quiet(data_space_code_in != 2'h0))
      else $error("request taken with wrong data space");
   chk_option_ignored: assert property (p_quiet(transfer_option_code_in > 3'h2))
      else $error("request taken with unserved option");
   chk_done_ack: assert property (configured_out && $past(configured_out) && !data_done_n_out |-> $past(mem_ack_in) || $past(mem_ack_in, 2))
      else $error("data done without array ack");
   chk_done_driven: assert property (!data_done_n_out |-> data_done_oe_out)
      else $error("data done low but floating");
   chk_grant_driven: assert property (!data_burst_grant_n_out |-> data_burst_grant_oe_out)
      else $error("burst grant low but floating");
   chk_burst_step: assert property (mem_req_out && mem_ack_in && !data_burst_want_n_in && !data_burst_grant_n_out |=> mem_addr_out == $past(mem_addr_out) + 32'h4)
      else $error("burst address did not step by four");
   chk_unconf_chain: assert property (!configured_out |-> !chained_reset_out_n_out)
      else $error("chained reset released before configuration");
   chk_config_release: assert property ($rose(configured_out) |-> !data_done_n_out ##1 chained_reset_out_n_out)
      else $error("configuration read not answered or chain held");
   chk_idle_float: assert property ((configured_out && !mem_req_out) [*4] |-> !data_done_oe_out && !instr_done_oe_out && !data_burst_grant_oe_out && !instr_burst_grant_oe_out)
      else $error("response driven while idle");

   cover property ($rose(configured_out));
   cover property (mem_ack_in && !data_burst_grant_n_out);
   cover property (!bus_invalid_n_in && !data_access_start_n_in);
endmodule // bchi_top_asserts
`default_nettype wire

/* File: testbench/bchi_top_tb.sv */
// self-checking bench of the channel interface
`default_nettype none
`define CHK(nm, ex, gt) \
   samples_checked++; \
   if ((gt) !== (ex)) \
   begin \
      errors++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, gt); \
   end

module bchi_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        dev_rst_n  = 1'b1;   // reset pin
   logic [31:0] addr       = 32'h0;
   logic [31:0] hdata      = 32'h0;
   logic        bus_invalid_n_n     = 1'b0;
   logic        rnw        = 1'b1;
   logic        dwant_n    = 1'b1;
   logic        dstart_n   = 1'b1;
   logic [1:0]  dspace     = 2'h0;
   logic [2:0]  opt        = 3'h0;
   logic        iwant_n    = 1'b1;
   logic        istart_n   = 1'b1;
   logic        ispace     = 1'b0;
   logic        pda_n      = 1'b1;   // pipelined data address
   logic        pia_n      = 1'b1;   // pipelined instruction address
   logic        mem_ack;
   logic [3:0]  delay      = 4'h1;
   logic        dgnt_n, dgnt_oe, ddone_n, ddone_oe, ignt_n, ignt_oe;
   logic        idone_n, idone_oe, pen_n, pen_oe, chain_n, mreq;
   logic        mwr, minstr, cfgd;
   logic [2:0]  mopt;
   logic [31:0] maddr, cfgw;
   int          errors = 0;
   int          samples_checked = 0;
   int          seed;
   logic [7:0]  base;                // configured block base
   logic [31:0] exp_q[$];            // expected word addresses

   always #20 ref_clk_in = ~ref_clk_in;

   bchi_top i_bchi_top (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .device_reset_n_in(dev_rst_n), .host_byte_address_in(addr),
      .host_data_in(hdata), .bus_invalid_n_in(bus_invalid_n_n),
      .read_not_write_in(rnw), .data_burst_want_n_in(dwant_n),
      .data_access_start_n_in(dstart_n), .data_space_code_in(dspace),
      .transfer_option_code_in(opt), .pipelined_data_addr_n_in(pda_n),
      .instr_burst_want_n_in(iwant_n), .instr_access_start_n_in(istart_n),
      .instr_space_code_in(ispace), .pipelined_instr_addr_n_in(pia_n),
      .mem_ack_in(mem_ack), .data_burst_grant_n_out(dgnt_n),
      .data_burst_grant_oe_out(dgnt_oe), .data_done_n_out(ddone_n),
      .data_done_oe_out(ddone_oe), .instr_burst_grant_n_out(ignt_n),
      .instr_burst_grant_oe_out(ignt_oe), .instr_done_n_out(idone_n),
      .instr_done_oe_out(idone_oe), .pipeline_accept_n_out(pen_n),
      .pipeline_accept_oe_out(pen_oe), .chained_reset_out_n_out(chain_n),
      .mem_req_out(mreq), .mem_addr_out(maddr), .mem_write_out(mwr),
      .mem_instr_out(minstr), .mem_opt_out(mopt), .configured_out(cfgd),
      .config_word_out(cfgw));

   bchi_mem_model i_bchi_mem_model (.ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in), .mem_req_in(mreq), .delay_in(delay),
      .mem_ack_out(mem_ack));

   ////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one-cycle request; the bus is scrambled afterwards
   task automatic request(input logic ins, input logic [31:0] a,
                          input logic [2:0] o, input logic w);
      @(posedge ref_clk_in);
      #2;
      addr = a;
      opt = o;
      rnw = ~w;
      if (ins)
         istart_n = 1'b0;
      else
         dstart_n = 1'b0;
      @(posedge ref_clk_in);
      #2;
      istart_n = 1'b1;
      dstart_n = 1'b1;
      addr = $urandom();
   endtask

   task automatic wait_done(input logic ins, input int lim);
      int n;
      n = 0;
      while ((ins ? idone_n : ddone_n) !== 1'b0 && n < lim)
      begin
         @(negedge ref_clk_in);
         n++;
      end
      `CHK("done", 1'b0, ins ? idone_n : ddone_n);
   endtask

   // the model queues every word address of the transfer
   task automatic access(input logic ins, input logic w, input int nw,
                         input logic p);
      logic [31:0] a, e;
      logic [2:0]  o;
      int          n;
      a = {base, 24'($urandom())};
      a[1:0] = 2'b00;
      o = ins ? 3'h0 : 3'($urandom_range(2, 0));
      delay = 4'($urandom_range(4, 1));
      for (int i = 0; i < nw; i++)
         exp_q.push_back(a + 32'(4 * i));
      if (p)
         exp_q.push_back(a ^ 32'h100);
      if (ins)
         iwant_n = (nw == 1);
      else
         dwant_n = (nw == 1);
      request(ins, a, o, w);
      if (p)
      begin
         // a second word rides in while the first is served
         @(posedge ref_clk_in);
         #2;
         `CHK("pen", 2'b01, {pen_n, pen_oe});
         pda_n = 1'b0;
         pia_n = 1'b0;
         request(ins, a ^ 32'h100, o, w);
         pda_n = 1'b1;
         pia_n = 1'b1;
      end
      while (exp_q.size() > 0)
      begin
         n = 0;
         while (mem_ack !== 1'b1 && n < 20)
         begin
            @(negedge ref_clk_in);
            n++;
         end
         e = exp_q.pop_front();
         `CHK("addr", e, maddr);
         `CHK("attr", {w, ins}, {mwr, minstr});
         if (!ins)
         begin
            `CHK("opt", o, mopt);
         end
         if (exp_q.size() > 0 && nw > 1)
         begin
            `CHK("grant", 1'b0, ins ? ignt_n : dgnt_n);
         end
         @(posedge ref_clk_in);
         #2;
         if (exp_q.size() == 1)
         begin
            iwant_n = 1'b1;
            dwant_n = 1'b1;
         end
         wait_done(ins, 4);
      end
      repeat (4) @(posedge ref_clk_in);
      #2;
      `CHK("float", 4'h0, {ddone_oe, dgnt_oe, idone_oe, ignt_oe});
   endtask

   task automatic configure();
      base = 8'($urandom());
      hdata = {base, 24'($urandom())};
      request(1'b0, 32'h0, 3'h0, 1'b0);
      wait_done(1'b0, 8);
      `CHK("cfg", hdata, cfgw);
      repeat (2) @(negedge ref_clk_in);
      `CHK("chain", 2'b11, {cfgd, chain_n});
   endtask

   task automatic refuse(input logic ins, input logic [31:0] a,
                         input logic [2:0] o);
      request(ins, a, o, 1'b0);
      repeat (6)
      begin
         @(negedge ref_clk_in);
         `CHK("quiet", 3'b011, {mreq, ddone_n, idone_n});
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = $urandom(8);
      repeat (6) @(posedge ref_clk_in);
      #2;
      sys_rst_in = 1'b0;
      bus_invalid_n_n = 1'b1;
      repeat (5) @(posedge ref_clk_in);
      #2;
      `CHK("unconf", 2'b00, {cfgd, chain_n});
      refuse(1'b0, 32'h0, 3'h1);
      configure();
      for (int k = 0; k < 11; k++)
      begin
         bus_invalid_n_n = (k != 0);
         dspace = (k > 0 && k < 4) ? 2'(k) : 2'h0;
         ispace = (k == 10);
         refuse(k == 10, {(k == 9) ? ~base : base, 24'h0},
                (k > 3 && k < 9) ? 3'(k - 1) : 3'h0);
      end
      bus_invalid_n_n = 1'b1;
      dspace = 2'h0;
      ispace = 1'b0;
      for (int k = 0; k < 10; k++)
         access(k[0], k[1] & ~k[0], (k < 4 || k > 7) ? 1 : 2 + k % 3, k > 7);
      dev_rst_n = 1'b0;
      repeat (6) @(posedge ref_clk_in);
      #2;
      dev_rst_n = 1'b1;
      repeat (6) @(posedge ref_clk_in);
      #2;
      `CHK("pinrst", 2'b00, {cfgd, chain_n});
      configure();
      access(1'b0, 1'b0, 2, 1'b0);
      conclude();
   end

   // cut a hang short after about ten thousand cycles
   initial
   begin
      #400000;
      errors++;
      conclude();
   end
endmodule // bchi_top_tb

bind bchi_top bchi_top_asserts i_bchi_top_asserts (.ref_clk_in,
   .sys_rst_in, .bus_invalid_n_in, .data_access_start_n_in,
   .instr_access_start_n_in, .data_space_code_in,
   .transfer_option_code_in, .data_burst_want_n_in, .mem_ack_in,
   .data_done_n_out, .data_done_oe_out, .data_burst_grant_n_out,
   .data_burst_grant_oe_out, .instr_done_oe_out,
   .instr_burst_grant_oe_out, .chained_reset_out_n_out, .mem_req_out,
   .mem_addr_out, .configured_out);
`default_nettype wire

/* File: verilog/bchi_pin_sync.v */
// three-stage synchroniser with agreement filter for one pin
`default_nettype none

module bchi_pin_sync
(
   input  wire ref_clk_in,    // system clock
   input  wire sys_rst_in,    // synchronous reset, active high
   input  wire pin_in,        // asynchronous pin level
   output reg  level_out      // filtered level, in clock domain
);

   reg s1_reg;                // first stage, read only by s2_reg
   reg s2_reg;                // second stage
   reg s3_reg;                // third stage

   // shift pin through three flops; accept a change once s2 and s3 agree
   always @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
         begin
            level_out <= s3_reg;
         end
      end
   end

endmodule // bchi_pin_sync

`default_nettype wire

/* File: verilog/bchi_regs.vh */
// constants of the burst channel host interface
`ifndef BCHI_REGS_VH
`define BCHI_REGS_VH

// data option codes that the block answers (0 up to this value)
`define BCHI_OPT_MAX      3'h2
// option code of a full 32-bit word access
`define BCHI_OPT_WORD     3'h0
// data address space code that the block accepts
`define BCHI_DSPACE_OK    2'h0
// address step between burst words, in bytes
`define BCHI_WORD_STEP    32'h00000004
// width of the block base field in the configuration word
`define BCHI_BASE_BITS    8
// value of the configuration word after reset
`define BCHI_CFG_RESET    32'h00000000

`endif

/* File: verilog/bchi_top.v */
// processor-side channel interface of a burst dram controller
`include "bchi_regs.vh"
`default_nettype none

// Overview of operation
// - burst words addressed internally, not from bus
// - block base at any multiple of its size in 32-bit space, decoded
// - no request taken while bus invalid low
// - read or write chosen from read-not-write input
// - drive data burst grant low while continuing
// - data done low marks each data completion
// - data taken only with space code zero
// - only data option codes 0, 1, 2 answered
// - pipelined data address captured during access
// - drive instruction burst grant while continuing
// - instruction done low per word, bursts too
// - instruction taken only with space code low
// - pipelined instruction address recorded during access
// - pipeline accept low when next address takable
// - reset returns block to unconfigured waiting state
// - chained reset low until configured
// - all channel signals on system clock
// - first word read after reset configures block
// - same-block accesses served one after another
module bchi_top
#(
   parameter BASE_BITS = `BCHI_BASE_BITS  // block base width, high bits
)
(
   input  wire        ref_clk_in,                  // system clock
   input  wire        sys_rst_in,                  // sync reset, high
   input  wire        device_reset_n_in,           // reset pin, low
   input  wire [31:0] host_byte_address_in,        // byte address bus
   input  wire [31:0] host_data_in,                // data bus, config
   input  wire        bus_invalid_n_in,            // high = valid
   input  wire        read_not_write_in,           // high = read
   input  wire        data_burst_want_n_in,        // data burst request
   input  wire        data_access_start_n_in,      // data request
   input  wire [1:0]  data_space_code_in,          // data space
   input  wire [2:0]  transfer_option_code_in,     // size and mode
   input  wire        pipelined_data_addr_n_in,    // pipelined data
   input  wire        instr_burst_want_n_in,       // instr burst req
   input  wire        instr_access_start_n_in,     // instr request
   input  wire        instr_space_code_in,         // instr space
   input  wire        pipelined_instr_addr_n_in,   // pipelined instr
   input  wire        mem_ack_in,                  // array word done
   output reg         data_burst_grant_n_out,      // data burst ack
   output reg         data_burst_grant_oe_out,     // drive enable
   output reg         data_done_n_out,             // data ready
   output reg         data_done_oe_out,            // drive enable
   output reg         instr_burst_grant_n_out,     // instr burst ack
   output reg         instr_burst_grant_oe_out,    // drive enable
   output reg         instr_done_n_out,            // instr ready
   output reg         instr_done_oe_out,           // drive enable
   output reg         pipeline_accept_n_out,       // pipeline enable
   output reg         pipeline_accept_oe_out,      // drive enable
   output reg         chained_reset_out_n_out,     // reset to next
   output reg         mem_req_out,                 // array access
   output reg  [31:0] mem_addr_out,                // array byte addr
   output reg         mem_write_out,               // array write
   output reg         mem_instr_out,               // instr access
   output reg  [2:0]  mem_opt_out,                 // option code
   output reg         configured_out,              // config taken
   output reg  [31:0] config_word_out              // config word
);

   ////////////////////////////////////////////////////////////////////
   // reset pin and engine states

   localparam [1:0] ST_IDLE = 2'h0;  // nothing in service
   localparam [1:0] ST_MEM  = 2'h1;  // array access in service
   localparam [1:0] ST_CFG  = 2'h2;  // configuration read answer

   wire       pin_level;     // synchronised reset pin level
   wire       rst;           // combined internal reset
   reg  [1:0] state_reg;     // engine state
   reg        cur_instr_reg; // channel in service is instructions

   // the reset pin comes from off chip, so it is filtered first
   bchi_pin_sync u_rst_sync
   (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .pin_in     (device_reset_n_in),
      .level_out  (pin_level)
   );

   assign rst = sys_rst_in | ~pin_level;

   ////////////////////////////////////////////////////////////////////
   // request qualification

   wire opt_ok;     // option code answered
   wire in_block;   // address inside configured block
   wire data_hit;   // data request qualified this edge
   wire instr_hit;  // instruction request qualified this edge
   wire busy;       // engine serving an access

   assign busy   = (state_reg != ST_IDLE);
   assign opt_ok = (transfer_option_code_in <= `BCHI_OPT_MAX);
   // base compared on the top bits only, so the block starts on a multiple of its size
   assign in_block = (host_byte_address_in[31:32-BASE_BITS] ==
                      config_word_out[31:32-BASE_BITS]);

   // unconfigured: only a full-word read is taken, as configuration
   assign data_hit = bus_invalid_n_in
                   & ~data_access_start_n_in
                   & (data_space_code_in == `BCHI_DSPACE_OK)
                   & opt_ok
                   & (configured_out ? in_block :
                      (read_not_write_in &
                       (transfer_option_code_in == `BCHI_OPT_WORD)));
   assign instr_hit = bus_invalid_n_in
                    & ~instr_access_start_n_in
                    & ~instr_space_code_in
                    & configured_out
                    & in_block;

   ////////////////////////////////////////////////////////////////////
   // pending request slots, one per channel

   reg        dp_valid_reg;   // data slot holds a request
   reg [31:0] dp_addr_reg;    // data slot address
   reg        dp_rw_reg;      // data slot read-not-write
   reg [2:0]  dp_opt_reg;     // data slot option
   reg        ip_valid_reg;   // instruction slot holds a request
   reg [31:0] ip_addr_reg;    // instruction slot address
   wire       take_data;      // engine pulls data slot
   wire       take_instr;     // engine pulls instruction slot
   wire       dp_set;         // data request lands in its slot
   wire       ip_set;         // instruction request lands in its slot
   wire       dp_valid_next;  // data slot state after this edge
   wire       ip_valid_next;  // instruction slot state after this edge

   // data wins a tie; the instruction channel simply waits its turn
   assign take_data  = (state_reg == ST_IDLE) & dp_valid_reg;
   assign take_instr = (state_reg == ST_IDLE) & ~dp_valid_reg
                     & ip_valid_reg;
   // while busy only a pipelined request is taken
   assign dp_set     = data_hit & (~dp_valid_reg | take_data)
                     & (~busy | ~pipelined_data_addr_n_in);
   assign ip_set     = instr_hit & (~ip_valid_reg | take_instr)
                     & (~busy | ~pipelined_instr_addr_n_in);
   // pipeline accept reads these, so it shows this cycle's true room
   assign dp_valid_next = (dp_valid_reg & ~take_data) | dp_set;
   assign ip_valid_next = (ip_valid_reg & ~take_instr) | ip_set;

   // capture requests; while busy only a pipelined one is taken
   always @(posedge ref_clk_in)
   begin
      if (rst)
      begin
         dp_valid_reg <= 1'b0;
         dp_addr_reg  <= 32'h00000000;
         dp_rw_reg    <= 1'b1;
         dp_opt_reg   <= 3'h0;
         ip_valid_reg <= 1'b0;
         ip_addr_reg  <= 32'h00000000;
      end
      else
      begin
         // a new request in the pull cycle still lands: set beats clear
         dp_valid_reg <= dp_valid_next;
         ip_valid_reg <= ip_valid_next;
         if (dp_set)
         begin
            dp_addr_reg  <= host_byte_address_in;
            dp_rw_reg    <= read_not_write_in;
            dp_opt_reg   <= transfer_option_code_in;
         end
         if (ip_set)
         begin
            ip_addr_reg  <= host_byte_address_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // access engine

   wire want_burst;  // channel in service asks to keep bursting

   assign want_burst = cur_instr_reg ? ~instr_burst_want_n_in
                                     : ~data_burst_want_n_in;

   // one access at a time; burst words step the address internally
   always @(posedge ref_clk_in)
   begin
      if (rst)
      begin
         state_reg       <= ST_IDLE;
         cur_instr_reg   <= 1'b0;
         mem_req_out     <= 1'b0;
         mem_addr_out    <= 32'h00000000;
         mem_write_out   <= 1'b0;
         mem_instr_out   <= 1'b0;
         mem_opt_out     <= 3'h0;
         data_done_n_out <= 1'b1;
         instr_done_n_out <= 1'b1;
         configured_out  <= 1'b0;
         config_word_out <= `BCHI_CFG_RESET;
      end
      else
      begin
         data_done_n_out  <= 1'b1;
         instr_done_n_out <= 1'b1;
         case (state_reg)
            ST_IDLE:
            begin
               if (take_data)
               begin
                  cur_instr_reg <= 1'b0;
                  mem_addr_out  <= dp_addr_reg;
                  mem_write_out <= ~dp_rw_reg;
                  mem_instr_out <= 1'b0;
                  mem_opt_out   <= dp_opt_reg;
                  if (configured_out)
                  begin
                     mem_req_out <= 1'b1;
                     state_reg   <= ST_MEM;
                  end
                  else
                  begin
                     state_reg   <= ST_CFG;
                  end
               end
               else if (take_instr)
               begin
                  cur_instr_reg <= 1'b1;
                  mem_addr_out  <= ip_addr_reg;
                  mem_write_out <= 1'b0;
                  mem_instr_out <= 1'b1;
                  mem_opt_out   <= 3'h0;
                  mem_req_out   <= 1'b1;
                  state_reg     <= ST_MEM;
               end
            end
            ST_MEM:
            begin
               if (mem_ack_in)
               begin
                  // each finished word gets its own ready pulse
                  if (cur_instr_reg)
                  begin
                     instr_done_n_out <= 1'b0;
                  end
                  else
                  begin
                     data_done_n_out <= 1'b0;
                  end
                  if (want_burst)
                  begin
                     mem_addr_out <= mem_addr_out + `BCHI_WORD_STEP;
                  end
                  else
                  begin
                     mem_req_out <= 1'b0;
                     state_reg   <= ST_IDLE;
                  end
               end
            end
            ST_CFG:
            begin
               // no array exists yet; the word on the bus is the setup
               config_word_out <= host_data_in;
               configured_out  <= 1'b1;
               data_done_n_out <= 1'b0;
               state_reg       <= ST_IDLE;
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // three-state responses and chained reset

   wire serve_d;  // data channel in service next cycle
   wire serve_i;  // instruction channel in service next cycle
   reg  srv_d_reg; // data channel being served
   reg  srv_i_reg; // instruction channel being served

   assign serve_d = (take_data) | (busy & ~cur_instr_reg
                    & ~((state_reg == ST_CFG) |
                        (mem_ack_in & ~want_burst)));
   assign serve_i = (take_instr) | (busy & cur_instr_reg
                    & ~(mem_ack_in & ~want_burst));

   // responses driven only while their channel is served; a done
   // pulse keeps its enable for the cycle in which it shows
   always @(posedge ref_clk_in)
   begin
      if (rst)
      begin
         srv_d_reg                <= 1'b0;
         srv_i_reg                <= 1'b0;
         data_burst_grant_n_out   <= 1'b1;
         data_burst_grant_oe_out  <= 1'b0;
         data_done_oe_out         <= 1'b0;
         instr_burst_grant_n_out  <= 1'b1;
         instr_burst_grant_oe_out <= 1'b0;
         instr_done_oe_out        <= 1'b0;
         pipeline_accept_n_out    <= 1'b1;
         pipeline_accept_oe_out   <= 1'b0;
         chained_reset_out_n_out  <= 1'b0;
      end
      else
      begin
         srv_d_reg <= serve_d;
         srv_i_reg <= serve_i;
         // grant while the served channel asks to keep bursting; data grant also needs configuration
         data_burst_grant_n_out  <= ~(serve_d & configured_out
                                      & ~data_burst_want_n_in);
         data_burst_grant_oe_out <= serve_d;
         data_done_oe_out        <= serve_d | srv_d_reg;
         instr_burst_grant_n_out <= ~(serve_i
                                      & ~instr_burst_want_n_in);
         instr_burst_grant_oe_out <= serve_i;
         instr_done_oe_out       <= serve_i | srv_i_reg;
         // next address takable when the served channel's slot is free
         pipeline_accept_n_out   <= ~((serve_d & ~dp_valid_next) |
                                      (serve_i & ~ip_valid_next));
         pipeline_accept_oe_out  <= serve_d | serve_i;
         chained_reset_out_n_out <= configured_out;
      end
   end

endmodule // bchi_top

`default_nettype wire
